// [rtl/dzp_pkg.sv]
// Package with register map, field layout and bus types of the doze and RC postscaler block
package dzp_pkg;
  localparam logic [31:0] CLOCK_DIVIDER_CONTROL_OFFSET = 32'h0000_0000;
  localparam int          INTERRUPT_DOZE_EXIT_BIT      = 15;
  localparam int          DOZE_RATIO_MSB               = 14;
  localparam int          DOZE_RATIO_LSB               = 12;
  localparam int          RATIO_APPLY_BIT              = 11;
  localparam int          POSTSCALE_MSB                = 10;
  localparam int          POSTSCALE_LSB                = 8;
  localparam logic [2:0]  DOZE_RATIO_RESET             = 3'h0;
  localparam logic [2:0]  POSTSCALE_RESET              = 3'h1;
  localparam logic [2:0]  POSTSCALE_MAX_CODE           = 3'h7;
  localparam logic [3:0]  POSTSCALE_MAX_SHIFT          = 4'h8;
  localparam logic [2:0]  SOURCE_FAST_RC_POSTSCALED    = 3'h7;
  localparam logic [2:0]  SOURCE_LOW_POWER_FAST_RC     = 3'h6;
  localparam logic [1:0]  HTRANS_NONSEQ                = 2'h2;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } dzp_ahb_req_type;

  typedef struct packed {
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
  } dzp_ahb_rsp_type;
endpackage : dzp_pkg

// [rtl/dzp_tick_divider.sv]
// Power-of-two tick divider: passes one of every 2**shift input ticks
`timescale 1ns/1ns
module dzp_tick_divider
  import dzp_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_tick_in,
  input  wire logic [3:0] i_shift,
  output logic            o_tick
);
  typedef struct packed {
    logic [7:0] count;
    logic       tick;
  } dzp_div_state_type;

  dzp_div_state_type st;
  dzp_div_state_type next_st;
  logic [7:0]        mask;

  always_comb begin
    mask    = 8'((9'h001 << i_shift) - 9'h001);
    next_st = st;
    next_st.tick = 1'b0;
    if (i_tick_in) begin
      if ((st.count & mask) == mask) begin
        next_st.tick  = 1'b1;
        next_st.count = 8'h00;
      end else begin
        next_st.count = st.count + 8'h01;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_tick = st.tick;
endmodule : dzp_tick_divider

// [rtl/dzp_clock_divider.sv]
// Doze ratio and fast RC postscaler control with its AHB-Lite register
//
// Overview of operation
// - With interrupt exit enabled, an interrupt ends doze and forces ratio 1:1.
// - Leaving doze by interrupt clears the ratio-apply enable bit 11 in hardware.
// - With interrupt exit disabled, interrupts change neither doze, enable nor ratio.
// - Ratio field 14:12 divides the processor clock by two to the code, up to 1:128.
// - Reset returns the processor-to-peripheral ratio field to 1:1.
// - Enable bit applies the ratio to the processor only; clear means 1:1.
// - Postscaler field 10:8 divides by two to the code, 111 gives 1:256; resets to 001.
// - Postscaler acts on the 8 MHz fast RC only when source selection is 111.
// - Postscaler acts on the 500 kHz low-power fast RC only when selection is 110.
// - Source code 110 is low-power fast RC, 111 is fast RC, both postscaled.
`timescale 1ns/1ns
module dzp_clock_divider
  import dzp_pkg::*;
(
  input  wire logic            i_clk,
  input  wire logic            i_rst,
  input  wire dzp_ahb_req_type i_ahb,
  output dzp_ahb_rsp_type      o_ahb,
  input  wire logic            i_interrupt,
  input  wire logic [2:0]      i_current_source_select,
  output logic                 o_sys_tick,
  output logic                 o_cpu_tick,
  output logic                 o_periph_tick,
  output logic                 o_doze_active
);
  typedef struct packed {
    logic        interrupt_doze_exit_enable;
    logic [2:0]  doze_ratio;
    logic        ratio_apply_enable;
    logic [2:0]  rc_postscale_select;
    logic        write_pending;
    logic [31:0] hrdata;
    logic [3:0]  sys_shift;
    logic [3:0]  cpu_shift;
    logic        periph_tick;
  } dzp_state_type;

  dzp_state_type st;
  dzp_state_type next_st;
  logic          addr_phase;

  // Power-on and master clear both land here: ratio 1:1, postscaler 1:2, doze off
  localparam dzp_state_type RESET_STATE = '{
    interrupt_doze_exit_enable: 1'b0,
    doze_ratio:                 DOZE_RATIO_RESET,
    ratio_apply_enable:         1'b0,
    rc_postscale_select:        POSTSCALE_RESET,
    write_pending:              1'b0,
    hrdata:                     32'h0000_0000,
    sys_shift:                  4'h0,
    cpu_shift:                  4'h0,
    periph_tick:                1'b0
  };

  // Postscaler is bypassed unless one of the two RC sources runs
  function automatic logic [3:0] post_shift(input logic [2:0] code, input logic [2:0] source);
    if (source != SOURCE_FAST_RC_POSTSCALED && source != SOURCE_LOW_POWER_FAST_RC) begin
      return 4'h0;
    end
    if (code == POSTSCALE_MAX_CODE) begin
      return POSTSCALE_MAX_SHIFT;
    end
    return {1'b0, code};
  endfunction : post_shift

  // Register word as software sees it; unimplemented bits stay zero
  function automatic logic [31:0] reg_image(input dzp_state_type s);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[INTERRUPT_DOZE_EXIT_BIT]              = s.interrupt_doze_exit_enable;
    v[DOZE_RATIO_MSB:DOZE_RATIO_LSB]        = s.doze_ratio;
    v[RATIO_APPLY_BIT]                      = s.ratio_apply_enable;
    v[POSTSCALE_MSB:POSTSCALE_LSB]          = s.rc_postscale_select;
    return v;
  endfunction : reg_image

  always_comb begin
    // Only whole words are mapped, so hsize is not decoded
    addr_phase = i_ahb.hready && i_ahb.hsel && (i_ahb.htrans == HTRANS_NONSEQ);
    next_st = st;
    next_st.periph_tick = 1'b1;
    // Write data stand in the data phase, one cycle after the address was taken
    if (st.write_pending) begin
      // Bits 7:0 are never stored
      next_st.interrupt_doze_exit_enable = i_ahb.hwdata[INTERRUPT_DOZE_EXIT_BIT];
      next_st.doze_ratio          = i_ahb.hwdata[DOZE_RATIO_MSB:DOZE_RATIO_LSB];
      next_st.ratio_apply_enable  = i_ahb.hwdata[RATIO_APPLY_BIT];
      next_st.rc_postscale_select = i_ahb.hwdata[POSTSCALE_MSB:POSTSCALE_LSB];
    end
    // Interrupt exit beats a same-cycle software set so the wake is never lost
    if (st.interrupt_doze_exit_enable && i_interrupt) begin
      next_st.ratio_apply_enable = 1'b0;
    end
    // Read image comes from next_st so a read right after a write sees the new value
    next_st.write_pending = addr_phase && i_ahb.hwrite && (i_ahb.haddr == CLOCK_DIVIDER_CONTROL_OFFSET);
    if (addr_phase && !i_ahb.hwrite && (i_ahb.haddr == CLOCK_DIVIDER_CONTROL_OFFSET)) begin
      next_st.hrdata = reg_image(next_st);
    end else if (addr_phase) begin
      next_st.hrdata = 32'h0000_0000;
    end
    // Shifts are registered from next_st, so a written setting reaches the dividers on the same edge the register takes it
    next_st.sys_shift = post_shift(next_st.rc_postscale_select, i_current_source_select);
    next_st.cpu_shift = next_st.ratio_apply_enable ? {1'b0, next_st.doze_ratio} : 4'h0;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= RESET_STATE;
    end else begin
      st <= next_st;
    end
  end

  // Divider counts are not restarted on a change, so the first period after a write may be long
  dzp_tick_divider u_sys_div (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_tick_in (1'b1),
    .i_shift   (st.sys_shift),
    .o_tick    (o_sys_tick)
  );

  // Processor clock is the postscaled system tick thinned by the doze ratio
  dzp_tick_divider u_cpu_div (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_tick_in (o_sys_tick),
    .i_shift   (st.cpu_shift),
    .o_tick    (o_cpu_tick)
  );

  // Zero wait states: the one register always answers in the next cycle, so ready is tied high
  assign o_ahb.hreadyout = 1'b1;
  assign o_ahb.hresp     = 1'b0;
  assign o_ahb.hrdata    = st.hrdata;
  assign o_periph_tick   = st.periph_tick;
  assign o_doze_active   = st.ratio_apply_enable;

  // Interrupt exit
  chk_irq_exit_clears: assert property (@(posedge i_clk) disable iff (i_rst)
    (st.interrupt_doze_exit_enable && i_interrupt) |=> (!st.ratio_apply_enable && st.cpu_shift == 4'h0))
    else $error("interrupt did not end doze");
  chk_irq_apply_bit: assert property (@(posedge i_clk) disable iff (i_rst)
    (st.interrupt_doze_exit_enable && i_interrupt && st.ratio_apply_enable) |=> $fell(o_doze_active))
    else $error("ratio apply bit not cleared by interrupt");
  chk_irq_ignored: assert property (@(posedge i_clk) disable iff (i_rst)
    (!st.interrupt_doze_exit_enable && i_interrupt && !st.write_pending) |=>
      ($stable(st.ratio_apply_enable) && $stable(st.doze_ratio)))
    else $error("interrupt changed doze with exit disabled");
  chk_irq_exit_full: assert property (@(posedge i_clk) disable iff (i_rst)
    (st.interrupt_doze_exit_enable && i_interrupt) ##1 (st.sys_shift == 4'h0 && !st.write_pending)[*2]
      |=> o_cpu_tick)
    else $error("processor clock not back to full rate after interrupt exit");

  // Doze ratio and peripheral clock
  // Ratio checks wait for steady cycles so the registered shift has reached the divider
  chk_ratio_two: assert property (@(posedge i_clk) disable iff (i_rst)
    (st.ratio_apply_enable && st.doze_ratio == 3'h1 && st.sys_shift == 4'h0)[*4] ##0 o_cpu_tick |=> !o_cpu_tick)
    else $error("ratio 1:2 gave back-to-back processor ticks");
  chk_ratio_four: assert property (@(posedge i_clk) disable iff (i_rst)
    (st.ratio_apply_enable && st.doze_ratio == 3'h2 && st.sys_shift == 4'h0)[*4] ##0 o_cpu_tick
      ##1 (st.ratio_apply_enable && st.doze_ratio == 3'h2 && st.sys_shift == 4'h0)[*2]
      |=> (!o_cpu_tick && !$past(o_cpu_tick) && !$past(o_cpu_tick, 2)))
    else $error("ratio 1:4 gave processor ticks closer than four cycles");
  chk_reset_ratio: assert property (@(posedge i_clk) disable iff (i_rst)
    $past(i_rst) |-> (st.doze_ratio == DOZE_RATIO_RESET && st.rc_postscale_select == POSTSCALE_RESET))
    else $error("reset values wrong");
  chk_no_doze_full: assert property (@(posedge i_clk) disable iff (i_rst)
    (!st.ratio_apply_enable && st.sys_shift == 4'h0)[*3] |=> (o_cpu_tick && o_periph_tick))
    else $error("processor clock divided while doze off");
  chk_cpu_on_sys: assert property (@(posedge i_clk) disable iff (i_rst)
    o_cpu_tick |-> $past(o_sys_tick))
    else $error("processor tick without a system tick");
  chk_periph_running: assert property (@(posedge i_clk) disable iff (i_rst)
    !$past(i_rst) |-> o_periph_tick)
    else $error("peripheral clock stopped");

  // Postscaler
  chk_bypass_other: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_current_source_select[2:1] != 2'h3)[*3] |=> o_sys_tick)
    else $error("postscaler applied to non-RC source");
  chk_lprc_post: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_current_source_select == SOURCE_LOW_POWER_FAST_RC && st.rc_postscale_select == 3'h1)[*4]
      ##0 o_sys_tick |=> !o_sys_tick)
    else $error("low-power RC not postscaled");
  chk_fast_rc_post: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_current_source_select == SOURCE_FAST_RC_POSTSCALED && st.rc_postscale_select == 3'h1)[*4]
      ##0 o_sys_tick |=> !o_sys_tick)
    else $error("fast RC not postscaled");

  // Register bus
  chk_write_lands: assert property (@(posedge i_clk) disable iff (i_rst)
    (st.write_pending && !(st.interrupt_doze_exit_enable && i_interrupt)) |=>
      ({st.interrupt_doze_exit_enable, st.doze_ratio, st.ratio_apply_enable, st.rc_postscale_select}
        == $past(i_ahb.hwdata[INTERRUPT_DOZE_EXIT_BIT:POSTSCALE_LSB])))
    else $error("register write did not land");
  chk_read_image: assert property (@(posedge i_clk) disable iff (i_rst)
    (addr_phase && !i_ahb.hwrite && i_ahb.haddr == CLOCK_DIVIDER_CONTROL_OFFSET) |=>
      (o_ahb.hrdata == {16'h0000, st.interrupt_doze_exit_enable, st.doze_ratio, st.ratio_apply_enable,
                        st.rc_postscale_select, 8'h00}))
    else $error("read data differ from register");
  chk_unmapped_zero: assert property (@(posedge i_clk) disable iff (i_rst)
    (addr_phase && i_ahb.haddr != CLOCK_DIVIDER_CONTROL_OFFSET) |=>
      (o_ahb.hrdata == 32'h0000_0000 && !st.write_pending))
    else $error("unmapped access not ignored");
  chk_low_byte_zero: assert property (@(posedge i_clk) disable iff (i_rst)
    o_ahb.hrdata[7:0] == 8'h00)
    else $error("unimplemented bits read nonzero");

  cov_doze_entered: cover property (@(posedge i_clk) disable iff (i_rst) $rose(o_doze_active));
  cov_irq_exit: cover property (@(posedge i_clk) disable iff (i_rst)
    st.interrupt_doze_exit_enable && i_interrupt && st.ratio_apply_enable);
  cov_max_post: cover property (@(posedge i_clk) disable iff (i_rst)
    st.sys_shift == POSTSCALE_MAX_SHIFT && o_sys_tick);
  cov_lprc_post: cover property (@(posedge i_clk) disable iff (i_rst)
    i_current_source_select == SOURCE_LOW_POWER_FAST_RC && st.sys_shift != 4'h0 && o_sys_tick);
  cov_irq_ignored: cover property (@(posedge i_clk) disable iff (i_rst)
    !st.interrupt_doze_exit_enable && i_interrupt && st.ratio_apply_enable);
endmodule : dzp_clock_divider

// [verif/dzp_testbench.sv]
// Self-checking bench for the doze ratio and RC postscaler block
`timescale 1ns/1ns
module testbench
  import dzp_pkg::*;
;
  logic            i_clk = 1'b0;
  logic            i_rst = 1'b1;
  logic            i_interrupt = 1'b0;
  logic [2:0]      i_current_source_select = 3'h0;
  logic [2:0]      srcs [3] = '{3'h7, 3'h6, 3'h0};
  dzp_ahb_req_type req_q = '0;
  dzp_ahb_req_type req;
  dzp_ahb_rsp_type rsp;
  logic            o_sys_tick, o_cpu_tick, o_periph_tick, o_doze_active;
  logic [31:0]     rd, ns, nc, np, ex;
  int              err_count = 0;
  int              total_checks = 0;

  // The bus hready is the one slave's hreadyout
  assign req = {req_q[$bits(dzp_ahb_req_type)-1:1], rsp.hreadyout};

  dzp_clock_divider dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_ahb(req), .o_ahb(rsp), .i_interrupt(i_interrupt),
    .i_current_source_select(i_current_source_select), .o_sys_tick(o_sys_tick), .o_cpu_tick(o_cpu_tick),
    .o_periph_tick(o_periph_tick), .o_doze_active(o_doze_active));

  initial begin
    forever #10 i_clk = ~i_clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic bus(input logic [31:0] addr, input logic wr, input logic [31:0] wdata);
    @(posedge i_clk);
    req_q <= '{hsel:1'b1, haddr:addr, htrans:HTRANS_NONSEQ, hwrite:wr, hsize:3'h2, hwdata:32'h0, hready:1'b1};
    do @(posedge i_clk); while (rsp.hreadyout !== 1'b1);
    req_q <= '{hsel:1'b0, haddr:addr, htrans:2'h0, hwrite:1'b0, hsize:3'h2, hwdata:wdata, hready:1'b1};
    do @(posedge i_clk); while (rsp.hreadyout !== 1'b1);
    rd = rsp.hrdata;
  endtask : bus

  // Settling span covers the longest divider period, since counters are not restarted on a change
  task automatic measure;
    ns = '0;
    nc = '0;
    np = '0;
    repeat (300) @(posedge i_clk);
    repeat (256) begin
      @(posedge i_clk);
      ns += o_sys_tick;
      nc += o_cpu_tick;
      np += o_periph_tick;
    end
  endtask : measure

  task automatic pulse_interrupt;
    @(posedge i_clk);
    i_interrupt <= 1'b1;
    @(posedge i_clk);
    i_interrupt <= 1'b0;
    repeat (2) @(posedge i_clk);
  endtask : pulse_interrupt

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (60000) @(posedge i_clk);
    err_count++;
    give_verdict();
  end

  initial begin
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    bus(32'h0, 1'b0, 32'h0);
    check("reset value", rd, 32'h0000_0100);
    bus(32'h0, 1'b1, 32'hFFFF_FFFF);
    bus(32'h0, 1'b0, 32'h0);
    check("register readback", rd, 32'h0000_FF00);
    bus(32'h4, 1'b1, 32'h0);
    bus(32'h4, 1'b0, 32'h0);
    check("unmapped read", rd, 32'h0);
    check("unmapped response", rsp.hresp, 32'h0);
    bus(32'h0, 1'b0, 32'h0);
    check("register kept", rd, 32'h0000_FF00);
    $display("test register access done");
    for (int s = 0; s < 3; s++) begin
      i_current_source_select <= srcs[s];
      for (int k = 0; k < 8; k++) begin
        bus(32'h0, 1'b1, 32'(k) << POSTSCALE_LSB);
        measure();
        ex = (srcs[s][2:1] == 2'b11) ? 32'd256 >> ((k == 7) ? 8 : k) : 32'd256;
        check("sys ticks", ns, ex);
        check("cpu ticks undozed", nc, ex);
      end
    end
    $display("test postscaler done");
    i_current_source_select <= 3'h0;
    for (int d = 0; d < 8; d++) begin
      bus(32'h0, 1'b1, (32'(d) << DOZE_RATIO_LSB) | 32'h0000_0800);
      measure();
      check("doze active", o_doze_active, 32'h1);
      check("sys ticks dozed", ns, 32'd256);
      check("cpu ticks dozed", nc, 32'd256 >> d);
      check("periph ticks", np, 32'd256);
    end
    $display("test doze ratio done");
    bus(32'h0, 1'b1, 32'h0000_B800);
    pulse_interrupt();
    check("doze after interrupt", o_doze_active, 32'h0);
    bus(32'h0, 1'b0, 32'h0);
    check("enable cleared", rd & 32'h0000_8800, 32'h0000_8000);
    measure();
    check("cpu ticks after exit", nc, 32'd256);
    bus(32'h0, 1'b1, 32'h0000_3800);
    pulse_interrupt();
    check("doze kept", o_doze_active, 32'h1);
    bus(32'h0, 1'b0, 32'h0);
    check("register kept", rd, 32'h0000_3800);
    measure();
    check("cpu ticks kept", nc, 32'd32);
    $display("test interrupt exit done");
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    bus(32'h0, 1'b0, 32'h0);
    check("value after reset", rd, 32'h0000_0100);
    $display("test second reset done");
    give_verdict();
  end
endmodule : testbench
